// *** hw/sbst_regs.svh ***
// constants of the scan test port
`ifndef SBST_REGS_SVH
`define SBST_REGS_SVH

`define SBST_IR_W          3
`define SBST_IR_EXTEST     3'h0
`define SBST_IR_IDCODE     3'h1
`define SBST_IR_SAMPLE_Z   3'h2
`define SBST_IR_SAMPLE     3'h4
`define SBST_IR_BYPASS     3'h7
`define SBST_IR_CAPTURE    3'h1
`define SBST_ID_W          32
// arbitrary identification value, bit 0 set
`define SBST_IDCODE        32'h0A5A_5001
`define SBST_BSR_W         16
`define SBST_TLR_TMS_COUNT 3'h5

`endif

// *** hw/sbst_pkg.sv ***
// types of the scan test port
package sbst_pkg;

   typedef enum logic [3:0] {
      SBST_TLR,
      SBST_IDLE,
      SBST_SEL_DR,
      SBST_CAP_DR,
      SBST_SHIFT_DR,
      SBST_EXIT1_DR,
      SBST_PAUSE_DR,
      SBST_EXIT2_DR,
      SBST_UPD_DR,
      SBST_SEL_IR,
      SBST_CAP_IR,
      SBST_SHIFT_IR,
      SBST_EXIT1_IR,
      SBST_PAUSE_IR,
      SBST_EXIT2_IR,
      SBST_UPD_IR
   } sbst_state_t;

endpackage

// *** hw/sbst_scan_reg.sv ***
// capture and shift stage of one serial scan register
`timescale 1ns/1ps
module sbst_scan_reg #(
   parameter int W = 2
) (
   // clock and reset
   input  wire logic         clock,
   input  wire logic         reset_n,
   input  wire logic         ce,
   // control
   input  wire logic         capture,
   input  wire logic         shift,
   input  wire logic         tdi,
   // data
   input  wire logic [W-1:0] cap_val,
   output logic      [W-1:0] sh
);

   logic [W-1:0] sh_reg;
   logic [W-1:0] sh_next;

   always_comb
   begin
      sh_next = sh_reg;
      if (capture)
      begin
         sh_next = cap_val;
      end
      else if (shift)
      begin
         // lsb leaves first
         sh_next = {tdi, sh_reg[W-1:1]};
      end
   end

   always_ff @(posedge clock)
   begin
      if (!reset_n)
      begin
         sh_reg <= '0;
      end
      else if (ce)
      begin
         sh_reg <= sh_next;
      end
   end

   assign sh = sh_reg;

endmodule

// *** hw/sbst_tap.sv ***
// boundary scan test access port of the burst sram
`timescale 1ns/1ps
`include "sbst_regs.svh"
module sbst_tap (
   // clock and reset
   input  wire logic                     clock,
   input  wire logic                     reset_n,
   input  wire logic                     ce,
   // test pins
   input  wire logic                     tck,
   input  wire logic                     tms,
   input  wire logic                     tms_float,
   input  wire logic                     tdi,
   input  wire logic                     tdi_float,
   output logic                          tdo,
   output logic                          tdo_oe_n,
   // ram pin ring
   input  wire logic [`SBST_BSR_W-1:0]   ram_pins,
   output logic      [`SBST_BSR_W-1:0]   bsr_out,
   output logic                          extest_en,
   output logic                          outputs_hiz,
   // status
   output sbst_pkg::sbst_state_t         tap_state
);
   import sbst_pkg::*;

   // pin synchronisers
   logic tck_s1, tck_s2, tck_s3;
   logic tms_s1, tms_s2, tdi_s1, tdi_s2;
   logic [`SBST_BSR_W-1:0] ram_s1, ram_s2;

   always_ff @(posedge clock)
   begin
      if (!reset_n)
      begin
         tck_s1 <= 1'b0;
         tck_s2 <= 1'b0;
         tck_s3 <= 1'b0;
         tms_s1 <= 1'b1;
         tms_s2 <= 1'b1;
         tdi_s1 <= 1'b1;
         tdi_s2 <= 1'b1;
         ram_s1 <= '0;
         ram_s2 <= '0;
      end
      else if (ce)
      begin
         tck_s1 <= tck;
         tck_s2 <= tck_s1;
         tck_s3 <= tck_s2;
         tms_s1 <= tms | tms_float;
         tms_s2 <= tms_s1;
         tdi_s1 <= tdi | tdi_float;
         tdi_s2 <= tdi_s1;
         ram_s1 <= ram_pins;
         ram_s2 <= ram_s1;
      end
   end

   logic rise, fall;
   assign rise = ce & tck_s2 & ~tck_s3;
   assign fall = ce & ~tck_s2 & tck_s3;

   // controller, instruction, bypass, output
   sbst_state_t            state_reg, state_next;
   logic [`SBST_IR_W-1:0]  ir_reg, ir_next;
   logic                   byp_reg, byp_next;
   logic                   tdo_reg, tdo_next;
   logic                   oen_reg, oen_next;
   logic [`SBST_BSR_W-1:0] upd_reg, upd_next;
   logic [`SBST_IR_W-1:0]  ir_sh;
   logic [`SBST_ID_W-1:0]  id_sh;
   logic [`SBST_BSR_W-1:0] bsr_sh;
   logic sel_bsr, sel_id, sel_byp, serial;

   assign sel_bsr = (ir_reg == `SBST_IR_EXTEST) ||
                    (ir_reg == `SBST_IR_SAMPLE) ||
                    (ir_reg == `SBST_IR_SAMPLE_Z);
   assign sel_id  = (ir_reg == `SBST_IR_IDCODE);
   assign sel_byp = !sel_bsr && !sel_id;

   assign serial = (state_reg == SBST_SHIFT_IR) ? ir_sh[0]  :
                   sel_bsr                      ? bsr_sh[0] :
                   sel_id                       ? id_sh[0]  :
                   byp_reg;

   always_comb
   begin
      state_next = state_reg;
      ir_next    = ir_reg;
      byp_next   = byp_reg;
      tdo_next   = tdo_reg;
      oen_next   = oen_reg;
      upd_next   = upd_reg;
      if (rise)
      begin
         case (state_reg)
            SBST_TLR:      state_next = tms_s2 ? SBST_TLR : SBST_IDLE;
            SBST_IDLE:     state_next = tms_s2 ? SBST_SEL_DR : SBST_IDLE;
            SBST_SEL_DR:   state_next = tms_s2 ? SBST_SEL_IR : SBST_CAP_DR;
            SBST_CAP_DR:   state_next = tms_s2 ? SBST_EXIT1_DR
                                               : SBST_SHIFT_DR;
            SBST_SHIFT_DR: state_next = tms_s2 ? SBST_EXIT1_DR
                                               : SBST_SHIFT_DR;
            SBST_EXIT1_DR: state_next = tms_s2 ? SBST_UPD_DR
                                               : SBST_PAUSE_DR;
            SBST_PAUSE_DR: state_next = tms_s2 ? SBST_EXIT2_DR
                                               : SBST_PAUSE_DR;
            SBST_EXIT2_DR: state_next = tms_s2 ? SBST_UPD_DR
                                               : SBST_SHIFT_DR;
            SBST_UPD_DR:   state_next = tms_s2 ? SBST_SEL_DR : SBST_IDLE;
            SBST_SEL_IR:   state_next = tms_s2 ? SBST_TLR : SBST_CAP_IR;
            SBST_CAP_IR:   state_next = tms_s2 ? SBST_EXIT1_IR
                                               : SBST_SHIFT_IR;
            SBST_SHIFT_IR: state_next = tms_s2 ? SBST_EXIT1_IR
                                               : SBST_SHIFT_IR;
            SBST_EXIT1_IR: state_next = tms_s2 ? SBST_UPD_IR
                                               : SBST_PAUSE_IR;
            SBST_PAUSE_IR: state_next = tms_s2 ? SBST_EXIT2_IR
                                               : SBST_PAUSE_IR;
            SBST_EXIT2_IR: state_next = tms_s2 ? SBST_UPD_IR
                                               : SBST_SHIFT_IR;
            SBST_UPD_IR:   state_next = tms_s2 ? SBST_SEL_DR : SBST_IDLE;
            default:       state_next = SBST_TLR;
         endcase
         if (state_next == SBST_TLR)
         begin
            ir_next = `SBST_IR_IDCODE;
         end
         if (state_reg == SBST_CAP_DR)
         begin
            byp_next = 1'b0;
         end
         else if (state_reg == SBST_SHIFT_DR && sel_byp)
         begin
            byp_next = tdi_s2;
         end
      end
      if (fall)
      begin
         if (state_reg == SBST_UPD_IR)
         begin
            ir_next = ir_sh;
         end
         if (state_reg == SBST_UPD_DR && sel_bsr)
         begin
            upd_next = bsr_sh;
         end
         oen_next = !(state_reg == SBST_SHIFT_DR ||
                      state_reg == SBST_SHIFT_IR);
         tdo_next = serial;
      end
   end

   always_ff @(posedge clock)
   begin
      if (!reset_n)
      begin
         state_reg <= SBST_TLR;
         ir_reg    <= `SBST_IR_IDCODE;
         byp_reg   <= 1'b0;
         tdo_reg   <= 1'b0;
         oen_reg   <= 1'b1;
         upd_reg   <= '0;
      end
      else if (ce)
      begin
         state_reg <= state_next;
         ir_reg    <= ir_next;
         byp_reg   <= byp_next;
         tdo_reg   <= tdo_next;
         oen_reg   <= oen_next;
         upd_reg   <= upd_next;
      end
   end

   sbst_scan_reg #(.W(`SBST_IR_W)) u_ir (
      .clock   (clock),
      .reset_n (reset_n),
      .ce      (ce),
      .capture (rise && state_reg == SBST_CAP_IR),
      .shift   (rise && state_reg == SBST_SHIFT_IR),
      .tdi     (tdi_s2),
      .cap_val (`SBST_IR_CAPTURE),
      .sh      (ir_sh)
   );

   sbst_scan_reg #(.W(`SBST_ID_W)) u_id (
      .clock   (clock),
      .reset_n (reset_n),
      .ce      (ce),
      .capture (rise && state_reg == SBST_CAP_DR && sel_id),
      .shift   (rise && state_reg == SBST_SHIFT_DR && sel_id),
      .tdi     (tdi_s2),
      .cap_val (`SBST_IDCODE),
      .sh      (id_sh)
   );

   sbst_scan_reg #(.W(`SBST_BSR_W)) u_bsr (
      .clock   (clock),
      .reset_n (reset_n),
      .ce      (ce),
      .capture (rise && state_reg == SBST_CAP_DR && sel_bsr),
      .shift   (rise && state_reg == SBST_SHIFT_DR && sel_bsr),
      .tdi     (tdi_s2),
      .cap_val (ram_s2),
      .sh      (bsr_sh)
   );

   assign tdo         = tdo_reg;
   assign tdo_oe_n    = oen_reg;
   assign bsr_out     = upd_reg;
   assign tap_state   = state_reg;
   // ram inputs are never gated here
   assign extest_en   = (ir_reg == `SBST_IR_EXTEST);
   assign outputs_hiz = (ir_reg == `SBST_IR_SAMPLE_Z);

   // checks
   logic [2:0] tms_cnt;
   always_ff @(posedge clock)
   begin
      if (!reset_n)
      begin
         tms_cnt <= 3'h0;
      end
      else if (rise)
      begin
         tms_cnt <= !tms_s2 ? 3'h0 : (tms_cnt == 3'h7) ? 3'h7
                                   : tms_cnt + 3'h1;
      end
   end

   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);

   sequence fall_in_byp_shift;
      fall && state_reg == SBST_SHIFT_DR && sel_byp;
   endsequence
   sequence rise_in_cap_ir;
      rise && state_reg == SBST_CAP_IR;
   endsequence

   tlr_five_a: assert property (
      rise && tms_s2 && tms_cnt == `SBST_TLR_TMS_COUNT - 3'h1
      |=> state_reg == SBST_TLR)
      else $error("five high tms rises did not reach reset state");
   tdo_enable_a: assert property (
      $past(fall) |-> tdo_oe_n != $past(state_reg == SBST_SHIFT_DR ||
                                       state_reg == SBST_SHIFT_IR))
      else $error("tdo enable does not follow shift state");
   tdo_fall_only_a: assert property (
      !$stable(tdo_reg) || !$stable(oen_reg) |-> $past(fall))
      else $error("tdo changed without falling test clock");
   state_rise_only_a: assert property (
      !$stable(state_reg) |-> $past(rise))
      else $error("state moved without rising test clock");
   ir_tlr_a: assert property (
      state_reg == SBST_TLR |-> ir_reg == `SBST_IR_IDCODE)
      else $error("instruction not identification in reset state");
   ir_capture_a: assert property (
      rise_in_cap_ir |=> ir_sh[1:0] == 2'h1)
      else $error("instruction capture pattern wrong");
   bypass_path_a: assert property (
      fall_in_byp_shift |=> tdo_reg == $past(byp_reg) && !tdo_oe_n)
      else $error("bypass bit not on tdo");
   extest_drive_a: assert property (
      extest_en && $past(fall && state_reg == SBST_UPD_DR) |->
      bsr_out == $past(bsr_sh))
      else $error("external test not driving boundary");
   powerup_a: assert property (
      $rose(reset_n) |-> state_reg == SBST_TLR && tdo_oe_n)
      else $error("port not reset after power-up");

endmodule

// *** verif/sbst_tester.sv ***
// board scan controller model driving the test pins
`timescale 1ns/1ps
module sbst_tester (
   // clock
   input  wire logic clock,
   // test pins
   output logic      tck,
   output logic      tms,
   output logic      tdi,
   input  wire logic tdo,
   input  wire logic tdo_oe_n
);
   // test clock stands low between frames
   initial
   begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b1;
   end

   // one test clock period of 16 clocks, tdo taken before the rise
   task automatic step(input logic m, input logic d, output logic q);
      tms <= m;
      tdi <= d;
      repeat (4) @(posedge clock);
      q = tdo_oe_n ? 1'bx : tdo;
      tck <= 1'b1;
      repeat (8) @(posedge clock);
      tck <= 1'b0;
      repeat (4) @(posedge clock);
   endtask

   // shift n bits lsb first, mode select high on the last
   task automatic scan(input int n, input logic [31:0] din,
                       output logic [31:0] dout);
      logic q;
      dout = '0;
      for (int i = 0; i < n; i++)
      begin
         step(i == n - 1, din[i], q);
         dout[i] = q;
      end
   endtask

   // five rises with mode select high
   task automatic rst5;
      logic q;
      repeat (5) step(1'b1, 1'b1, q);
   endtask
endmodule

// *** verif/tb_sbst_tap.sv ***
// self-checking bench of the scan test port
`timescale 1ns/1ps
`include "sbst_regs.svh"
module tb_sbst_tap;
   import sbst_pkg::*;
   logic                  clock = 1'b0;
   logic                  reset_n = 1'b0;
   logic                  ce = 1'b1;
   logic                  tms_float = 1'b0;
   logic                  tdi_float = 1'b0;
   logic [`SBST_BSR_W-1:0] ram_pins = '0;
   logic [`SBST_BSR_W-1:0] bsr_out;
   logic                  tck, tms, tdi, tdo, tdo_oe_n;
   logic                  extest_en, outputs_hiz;
   sbst_state_t           tap_state;
   int                    n_mismatch = 0;
   int                    comparisons = 0;
   logic                  q;
   logic [31:0]           d;
   logic [2:0]            codes [4];

   always #5 clock = ~clock;

   sbst_tap sbst_tap_i (.clock(clock), .reset_n(reset_n), .ce(ce),
      .tck(tck), .tms(tms), .tms_float(tms_float), .tdi(tdi),
      .tdi_float(tdi_float), .tdo(tdo), .tdo_oe_n(tdo_oe_n),
      .ram_pins(ram_pins), .bsr_out(bsr_out), .extest_en(extest_en),
      .outputs_hiz(outputs_hiz), .tap_state(tap_state));

   sbst_tester sbst_tester_i (.clock(clock), .tck(tck), .tms(tms),
      .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n));

   task automatic chk(input string nm, input logic [31:0] s, e);
      comparisons++;
      if (s !== e)
      begin
         n_mismatch++;
         $display("BAD %s exp %h seen %h", nm, e, s);
      end
   endtask

   task automatic end_of_test;
      if (n_mismatch == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // walk mode select bits lsb first
   task automatic nav(input logic [3:0] m, input int n);
      for (int i = 0; i < n; i++)
         sbst_tester_i.step(m[i], 1'b1, q);
   endtask

   // instruction scan from idle back to idle
   task automatic ir(input logic [2:0] c, output logic [31:0] o);
      nav(4'h3, 4);
      sbst_tester_i.scan(3, {29'h0, c}, o);
      nav(4'h1, 2);
   endtask

   // data scan from idle back to idle
   task automatic dr(input int n, input logic [31:0] i,
                     output logic [31:0] o);
      nav(4'h1, 3);
      sbst_tester_i.scan(n, i, o);
      nav(4'h1, 2);
   endtask

   task automatic t_reset;
      repeat (20) @(posedge clock);
      chk("state", tap_state, SBST_TLR);
      chk("oe_n", tdo_oe_n, 1'b1);
      chk("ext", extest_en, 1'b0);
      chk("bsr", bsr_out, 16'h0000);
   endtask

   task automatic t_idcode;
      nav(4'h0, 1);
      dr(32, 32'hFFFF_FFFF, d);
      chk("idcode", d, `SBST_IDCODE);
      chk("oe_idle", tdo_oe_n, 1'b1);
   endtask

   task automatic t_bypass;
      ir(`SBST_IR_BYPASS, d);
      chk("ircap", d[2:0], `SBST_IR_CAPTURE);
      dr(4, 32'hB, d);
      chk("byp", d[3:0], 4'h6);
      tdi_float <= 1'b1;
      dr(3, 32'h0, d);
      chk("tdifl", d[2:0], 3'h6);
      tdi_float <= 1'b0;
   endtask

   task automatic t_boundary;
      ram_pins <= 16'hA5C3;
      ir(`SBST_IR_SAMPLE, d);
      dr(16, 32'h3C96, d);
      chk("cap", d[15:0], 16'hA5C3);
      chk("upd", bsr_out, 16'h3C96);
      codes = '{3'h0, 3'h2, 3'h4, 3'h7};
      foreach (codes[k])
      begin
         ir(codes[k], d);
         chk("ircap", d[2:0], `SBST_IR_CAPTURE);
         chk("ext", extest_en, codes[k] == 3'h0);
         chk("hiz", outputs_hiz, codes[k] == 3'h2);
      end
   endtask

   task automatic t_five;
      ir(`SBST_IR_EXTEST, d);
      dr(16, 32'h5AA5, d);
      chk("excap", d[15:0], 16'hA5C3);
      chk("exdrv", bsr_out, 16'h5AA5);
      nav(4'h1, 3);
      sbst_tester_i.rst5();
      chk("tlr", tap_state, SBST_TLR);
      chk("irpre", extest_en, 1'b0);
      nav(4'h0, 1);
      tms_float <= 1'b1;
      nav(4'h0, 2);
      chk("tmsfl", tap_state, SBST_SEL_IR);
      nav(4'h0, 3);
      chk("tmsfl2", tap_state, SBST_TLR);
      tms_float <= 1'b0;
   endtask

   initial
   begin
      repeat (100000) @(posedge clock);
      n_mismatch++;
      end_of_test();
   end

   initial
   begin
      repeat (8) @(posedge clock);
      reset_n <= 1'b1;
      t_reset();
      t_idcode();
      t_bypass();
      t_boundary();
      t_five();
      end_of_test();
   end
endmodule
